// [mhrp_register_port.sv]
// host register bank of a four-axis motion controller
// Operation
// - done register is 8 bits, four axis flags low, upper four read zero
// - done bit 0 shows first axis finished
// - done bit 1 shows second axis finished
// - done bit 2 shows third axis finished
// - done bit 3 shows fourth axis finished
// - control bits 3..0 always read zero whatever is written
// - control bit 6 enables interrupt on transmit buffer empty
// - control bit 5 enables interrupt on input buffer full
// - control bit 4 enables interrupt on axis done or error
// - 8-bit slave at odd byte addresses in short address space
// - default base FF80 hex, registers at base plus odd offset
`timescale 1ns/1ns
`include "mhrp_regs.svh"
module mhrp_register_port (
    input wire logic sys_clk, // 10 MHz clock
    input wire logic reset, // synchronous reset, high
    input wire logic [15:0] bus_addr, // short-space byte address
    input wire logic bus_strobe, // one-cycle access strobe
    input wire logic bus_write, // 1 write, 0 read
    input wire logic [7:0] bus_wdata, // write data
    output logic [7:0] bus_rdata, // read data, registered
    output logic bus_ack, // one-cycle acknowledge
    input wire logic [15:0] base_addr, // board base, FF80 by default
    input wire logic [3:0] axis_done, // per-axis done levels
    input wire logic done_error, // error status condition level
    input wire logic tx_empty, // outgoing char buffer empty level
    input wire logic rx_full, // input char buffer full level
    input wire logic [7:0] status_in, // controller status byte
    input wire logic [7:0] resp_char, // response char from interpreter
    output logic [7:0] cmd_char, // command char to interpreter
    output logic cmd_char_wr, // pulse: command char written
    output logic resp_char_rd, // pulse: response char taken
    output logic [7:0] irq_vector, // interrupt vector number
    output logic irq_req // interrupt request, level
);
    localparam logic [7:0] CTRL_RST = `MHRP_CTRL_RESET;
    logic [7:0] rd_nxt;
    logic [7:0] done_byte;
    logic [7:0] ctrl_byte;
    logic acc;
    logic rd_any;
    // decoded actions for the command, control and vector writes and the command read
    logic wr_cmd;
    logic rd_cmd;
    logic wr_ctrl;
    logic wr_vector;
    // interrupt enable fields of the control byte
    logic irq_global_enable_r;
    logic tx_empty_irq_enable_r;
    logic rx_full_irq_enable_r;
    logic done_error_irq_enable_r;
    logic any_done;
    logic src_tx_empty;
    logic src_rx_full;
    logic src_done_err;
    logic irq_nxt;
    mhrp_dec_if dif();

    // true when the accepted access hits one register in one direction
    function automatic logic access_to(
        input logic taken,
        input logic is_write,
        input logic want_write,
        input mhrp_pkg::mhrp_sel_t sel,
        input mhrp_pkg::mhrp_sel_t want_sel
    );
        return taken && (is_write == want_write) && (sel == want_sel);
    endfunction

    mhrp_decode u_dec (
        .addr(bus_addr),
        .base(base_addr),
        .d(dif)
    );

    // even or off-window addresses never form an access
    assign acc = bus_strobe && dif.hit;
    assign rd_any = acc && !bus_write;
    assign wr_cmd = access_to(acc, bus_write, 1'b1, dif.sel,
                              mhrp_pkg::MHRP_SEL_CMD);
    assign rd_cmd = access_to(acc, bus_write, 1'b0, dif.sel,
                              mhrp_pkg::MHRP_SEL_CMD);
    assign wr_ctrl = access_to(acc, bus_write, 1'b1, dif.sel,
                               mhrp_pkg::MHRP_SEL_CTRL);
    assign wr_vector = access_to(acc, bus_write, 1'b1, dif.sel,
                                 mhrp_pkg::MHRP_SEL_VECTOR);

    // one done flag per axis, upper nibble tied low
    assign done_byte[0] = axis_done[0];
    assign done_byte[1] = axis_done[1];
    assign done_byte[2] = axis_done[2];
    assign done_byte[3] = axis_done[3];
    assign done_byte[7:4] = 4'h0;

    // the low nibble has no storage, so writes to it are lost
    assign ctrl_byte = {irq_global_enable_r, tx_empty_irq_enable_r,
                        rx_full_irq_enable_r, done_error_irq_enable_r,
                        4'h0};

    // any one axis is enough; there is no per-axis mask
    assign any_done = |axis_done;
    assign src_tx_empty = tx_empty_irq_enable_r && tx_empty;
    assign src_rx_full = rx_full_irq_enable_r && rx_full;
    assign src_done_err = done_error_irq_enable_r &&
                          (any_done || done_error);
    assign irq_nxt = irq_global_enable_r &&
                     (src_tx_empty || src_rx_full || src_done_err);

    // each enable bit is its own flop; one write loads all four
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_global_enable_r <= CTRL_RST[`MHRP_BIT_IRQ_GLOBAL];
        end else if (wr_ctrl) begin
            irq_global_enable_r <= bus_wdata[`MHRP_BIT_IRQ_GLOBAL];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tx_empty_irq_enable_r <= CTRL_RST[`MHRP_BIT_TX_EMPTY];
        end else if (wr_ctrl) begin
            tx_empty_irq_enable_r <= bus_wdata[`MHRP_BIT_TX_EMPTY];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rx_full_irq_enable_r <= CTRL_RST[`MHRP_BIT_RX_FULL];
        end else if (wr_ctrl) begin
            rx_full_irq_enable_r <= bus_wdata[`MHRP_BIT_RX_FULL];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            done_error_irq_enable_r <= CTRL_RST[`MHRP_BIT_DONE_ERR];
        end else if (wr_ctrl) begin
            done_error_irq_enable_r <= bus_wdata[`MHRP_BIT_DONE_ERR];
        end
    end

    // plain storage; the host reads it back when servicing a request
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_vector <= `MHRP_VECTOR_RESET;
        end else if (wr_vector) begin
            irq_vector <= bus_wdata;
        end
    end

    // the interpreter behind the data port sees one pulse per access
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cmd_char <= 8'h00;
        end else if (wr_cmd) begin
            cmd_char <= bus_wdata;
        end
    end

    // data and pulse load on the same edge, so the pulse finds it valid
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cmd_char_wr <= 1'b0;
        end else begin
            cmd_char_wr <= wr_cmd;
        end
    end

    // a read of the data port consumes the response character
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            resp_char_rd <= 1'b0;
        end else begin
            resp_char_rd <= rd_cmd;
        end
    end

    // read data is picked from the decoded slot at the accepting edge
    always_comb begin
        case (dif.sel)
            mhrp_pkg::MHRP_SEL_CMD: rd_nxt = resp_char;
            mhrp_pkg::MHRP_SEL_DONE: rd_nxt = done_byte;
            mhrp_pkg::MHRP_SEL_CTRL: rd_nxt = ctrl_byte;
            mhrp_pkg::MHRP_SEL_STATUS: rd_nxt = status_in;
            mhrp_pkg::MHRP_SEL_VECTOR: rd_nxt = irq_vector;
            // spare slots answer but read zero
            mhrp_pkg::MHRP_SEL_SPARE: rd_nxt = 8'h00;
            default: rd_nxt = 8'h00;
        endcase
    end

    // the acknowledge follows one cycle after the accepted strobe;
    // even or off-window addresses get none, so the master times out
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= acc;
        end
    end

    // read data holds between reads, so a slow host can pick it up late
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bus_rdata <= 8'h00;
        end else if (rd_any) begin
            bus_rdata <= rd_nxt;
        end
    end

    // registered so the request pin never carries decode glitches
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= irq_nxt;
        end
    end
endmodule // mhrp_register_port

// [mhrp_regs.svh]
// register offsets, field positions and reset values of the host register port
`ifndef MHRP_REGS_SVH
`define MHRP_REGS_SVH
`define MHRP_BASE_ADDR 16'hFF80
`define MHRP_OFS_CMD_CHAR 4'h1
`define MHRP_OFS_DONE 4'h3
`define MHRP_OFS_IRQ_CTRL 4'h5
`define MHRP_OFS_STATUS 4'h7
`define MHRP_OFS_VECTOR 4'h9
`define MHRP_OFS_SPARE_A 4'hB
`define MHRP_OFS_SPARE_B 4'hD
`define MHRP_OFS_SPARE_C 4'hF
`define MHRP_BIT_IRQ_GLOBAL 7
`define MHRP_BIT_TX_EMPTY 6
`define MHRP_BIT_RX_FULL 5
`define MHRP_BIT_DONE_ERR 4
`define MHRP_CTRL_WMASK 8'hF0
`define MHRP_CTRL_RESET 8'h00
`define MHRP_VECTOR_RESET 8'h00
`define MHRP_AXES 4
`endif

// [mhrp_pkg.sv]
// types shared by the host register port
package mhrp_pkg;
    typedef enum logic [3:0] {
        MHRP_SEL_CMD,
        MHRP_SEL_DONE,
        MHRP_SEL_CTRL,
        MHRP_SEL_STATUS,
        MHRP_SEL_VECTOR,
        MHRP_SEL_SPARE,
        MHRP_SEL_NONE
    } mhrp_sel_t;
endpackage

// [mhrp_dec_if.sv]
// decoded access signals passed from the address decoder to the bank
`timescale 1ns/1ns
interface mhrp_dec_if;
    mhrp_pkg::mhrp_sel_t sel;
    logic hit;
    modport dec (output sel, output hit);
    modport bank (input sel, input hit);
endinterface

// [mhrp_decode.sv]
// short-space odd-byte address decoder
`timescale 1ns/1ns
`include "mhrp_regs.svh"
module mhrp_decode (
    input wire logic [15:0] addr, // bus byte address
    input wire logic [15:0] base, // board base address
    mhrp_dec_if.dec d // decoded select
);
    // only odd addresses inside the 16-byte window answer
    always_comb begin
        d.hit = (addr[15:4] == base[15:4]) && addr[0];
        case (addr[3:0])
            `MHRP_OFS_CMD_CHAR: d.sel = mhrp_pkg::MHRP_SEL_CMD;
            `MHRP_OFS_DONE: d.sel = mhrp_pkg::MHRP_SEL_DONE;
            `MHRP_OFS_IRQ_CTRL: d.sel = mhrp_pkg::MHRP_SEL_CTRL;
            `MHRP_OFS_STATUS: d.sel = mhrp_pkg::MHRP_SEL_STATUS;
            `MHRP_OFS_VECTOR: d.sel = mhrp_pkg::MHRP_SEL_VECTOR;
            `MHRP_OFS_SPARE_A,
            `MHRP_OFS_SPARE_B,
            `MHRP_OFS_SPARE_C: d.sel = mhrp_pkg::MHRP_SEL_SPARE;
            default: d.sel = mhrp_pkg::MHRP_SEL_NONE;
        endcase
    end
endmodule // mhrp_decode

// [mhrp_register_port_chk.sv]
// assertions on the host register port pins
`timescale 1ns/1ns
module mhrp_register_port_chk (
    input wire logic sys_clk, // bus clock
    input wire logic reset, // synchronous reset, high
    input wire logic bus_strobe, // access strobe
    input wire logic bus_write, // write select
    input wire logic bus_ack, // acknowledge pulse
    input wire logic cmd_char_wr, // command char pulse
    input wire logic resp_char_rd, // response char pulse
    input wire logic done_error, // error condition level
    input wire logic tx_empty, // transmit empty level
    input wire logic rx_full, // input full level
    input wire logic irq_req, // interrupt request
    input wire logic [15:0] bus_addr, // byte address
    input wire logic [15:0] base_addr, // board base
    input wire logic [7:0] bus_wdata, // write data
    input wire logic [7:0] bus_rdata, // read data
    input wire logic [7:0] cmd_char, // command char
    input wire logic [7:0] irq_vector, // vector register
    input wire logic [3:0] axis_done // per-axis done levels
);
    logic hit, rd_hit, src, rd_data_port;
    logic [7:0] ctrl_r;
    assign hit = bus_strobe && bus_addr[15:4] == base_addr[15:4]
        && bus_addr[0];
    assign rd_hit = hit && !bus_write;
    assign rd_data_port = rd_hit && bus_addr[3:0] == 4'h1;
    assign src = ctrl_r[7] && (ctrl_r[6] && tx_empty || ctrl_r[5] && rx_full
        || ctrl_r[4] && (|axis_done || done_error));
    // mirror of the control byte so a request is traced to its cause
    always_ff @(posedge sys_clk) begin
        if (reset)
            ctrl_r <= 8'h00;
        else if (hit && bus_write && bus_addr[3:0] == 4'h5)
            ctrl_r <= bus_wdata & 8'hF0;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_ack_hit:
    assert property (hit |=> bus_ack) else $error("missing ack");
    a_ack_miss:
    assert property (!hit |=> !bus_ack) else $error("stray ack");
    a_done_read:
    assert property (rd_hit && bus_addr[3:0] == 4'h3 |=>
        bus_rdata == {4'h0, $past(axis_done)}) else $error("done byte");
    a_ctrl_read:
    assert property (rd_hit && bus_addr[3:0] == 4'h5 |=>
        bus_rdata == $past(ctrl_r)) else $error("control byte");
    a_irq_gate:
    assert property (!ctrl_r[7] |=> !irq_req) else $error("ungated irq");
    a_irq_source:
    assert property (irq_req == $past(src)) else $error("irq source");
    a_cmd_write:
    assert property (hit && bus_write && bus_addr[3:0] == 4'h1 |=>
        cmd_char_wr && cmd_char == $past(bus_wdata)) else $error("cmd");
    a_resp_pulse:
    assert property (resp_char_rd == $past(rd_data_port))
        else $error("response pulse");
    a_vec_write:
    assert property (hit && bus_write && bus_addr[3:0] == 4'h9 |=>
        irq_vector == $past(bus_wdata)) else $error("vector");
endmodule // mhrp_register_port_chk

// [mhrp_host_model.sv]
// bus master host issuing byte accesses
`timescale 1ns/1ns
module mhrp_host_model (
    input wire logic sys_clk, // bus clock
    output logic [15:0] bus_addr, // byte address
    output logic bus_strobe, // access strobe
    output logic bus_write, // write select
    output logic [7:0] bus_wdata // write data
);
    initial begin
        bus_addr = 16'h0000;
        bus_strobe = 1'b0;
        bus_write = 1'b0;
        bus_wdata = 8'h00;
    end
    task automatic acc(input logic [15:0] a, input logic w,
        input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_write <= w;
        bus_wdata <= d;
        bus_strobe <= 1'b1;
        @(posedge sys_clk);
        bus_strobe <= 1'b0;
        // released address and data lines invert so a stale value never looks valid; the write select holds
        bus_addr <= ~a;
        bus_wdata <= ~d;
    endtask
endmodule // mhrp_host_model

// [mhrp_register_port_tb_top.sv]
// testbench top for the host register port
`timescale 1ns/1ns
module mhrp_register_port_tb_top;
    logic sys_clk = 0, reset = 1, done_error = 0, tx_empty = 0, rx_full = 0;
    logic bus_strobe, bus_write, bus_ack, cmd_char_wr, irq_req;
    logic [15:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, cmd_char, irq_vector, c;
    logic [7:0] status_in = 0, resp_char = 0;
    logic [3:0] axis_done = 0;
    logic [8:0] exp_q[$], e;
    logic [6:0] v;
    logic irq_exp;
    int n_fail = 0, n_compared = 0;
    mhrp_host_model i_host (.sys_clk, .bus_addr, .bus_strobe, .bus_write,
        .bus_wdata);
    mhrp_register_port i_dut (.sys_clk, .reset, .bus_addr, .bus_strobe,
        .bus_write, .bus_wdata, .bus_rdata, .bus_ack, .base_addr(16'hFF80),
        .axis_done, .done_error, .tx_empty, .rx_full, .status_in,
        .resp_char, .cmd_char, .cmd_char_wr, .resp_char_rd(), .irq_vector,
        .irq_req);
    initial forever #50 sys_clk = ~sys_clk;
    task automatic chk(input logic [7:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic got, exp);
        chk({7'h0, got}, {7'h0, exp});
    endtask
    task automatic chk_ack(input logic got, exp);
        chk({7'h0, got}, {7'h0, exp});
    endtask
    task automatic rd(input logic [3:0] o, input logic [7:0] x);
        exp_q.push_back({1'b1, x});
        i_host.acc({12'hFF8, o}, 1'b0, 8'h00);
    endtask
    task automatic wr(input logic [3:0] o, input logic [7:0] d);
        exp_q.push_back(9'h000);
        i_host.acc({12'hFF8, o}, 1'b1, d);
    endtask
    task automatic report_and_stop;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(negedge sys_clk) begin
        if (bus_ack === 1'b1) begin
            chk_ack(exp_q.size() > 0, 1'b1);
            if (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                if (e[8])
                    chk(bus_rdata, e[7:0]);
            end
        end
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        report_and_stop;
    end
    initial begin
        void'($urandom(8));
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        rd(4'h5, 8'h00);
        rd(4'h9, 8'h00);
        for (int i = 0; i < 16; i++) begin
            v = 7'($urandom);
            c = 8'($urandom);
            axis_done <= v[6:3];
            {done_error, tx_empty, rx_full} <= v[2:0];
            status_in <= c;
            resp_char <= ~c;
            wr(4'h5, c);
            rd(4'h5, c & 8'hF0);
            wr(4'h1, c);
            rd(4'h3, {4'h0, v[6:3]});
            rd(4'h7, c);
            rd(4'h1, ~c);
            wr(4'h9, ~c);
            rd(4'h9, ~c);
            wr(4'hD, c);
            rd(4'hD, 8'h00);
            i_host.acc({12'hFF8, c[3:1], 1'b0}, 1'b1, c);
            i_host.acc({1'b0, ~c[6:0], 8'h85}, 1'b1, c);
            irq_exp = c[7] && (c[6] && v[1] || c[5] && v[0]
                || c[4] && |v[6:2]);
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            chk_irq(irq_req, irq_exp);
            @(posedge sys_clk);
        end
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rd(4'h5, 8'h00);
        rd(4'h9, 8'h00);
        @(negedge sys_clk);
        chk_irq(irq_req, 1'b0);
        @(posedge sys_clk);
        chk_ack(exp_q.size() == 0, 1'b1);
        repeat (3) @(posedge sys_clk);
        report_and_stop;
    end
endmodule // mhrp_register_port_tb_top
bind mhrp_register_port mhrp_register_port_chk i_chk (.sys_clk, .reset,
    .bus_strobe, .bus_write, .bus_ack, .cmd_char_wr, .resp_char_rd,
    .done_error,
    .tx_empty, .rx_full, .irq_req, .bus_addr, .base_addr, .bus_wdata,
    .bus_rdata, .cmd_char, .irq_vector, .axis_done);
